// [core/sfc_flash_cmd.sv]
// Serial flash command interpreter: decodes framed serial commands on the
// link clock and applies their effects in the core clock domain.
// Assumes the host drives select, serial clock and data lines and keeps
// select high for at least 5 core clock periods between frames.
`timescale 1ns/10ps

module sfc_flash_cmd (
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_spi_sclk,
  input  wire logic       i_spi_csn,
  input  wire logic       i_io0_in,
  input  wire logic       i_io1_in,
  output logic            o_io0_out,
  output logic            o_io0_oe,
  output logic            o_io1_out,
  output logic            o_io1_oe,
  output logic            o_busy,
  output logic            o_write_permit_latch,
  output logic            o_deep_sleep,
  output logic [15:0]     o_status,
  output logic            o_cmd_valid,
  output sfc_pkg::sfc_cmd_t o_cmd
);
  import sfc_pkg::*;

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef struct packed {
    sfc_phase_t phase;
    logic [5:0] cnt;
    logic [7:0] sr;
    sfc_info_t  info;
    logic [7:0] osr;
    logic [3:0] ocnt;
    logic [1:0] idx;
    logic       wip_s1;
    logic       wip_s2;
  } sfc_link_t;

  typedef struct packed {
    logic       io0_out;
    logic       io0_oe;
    logic       io1_out;
    logic       io1_oe;
  } sfc_tx_t;

  typedef struct packed {
    logic        sel_s1;
    logic        sel_s2;
    logic        sel_s3;
    logic        busy;
    logic [11:0] tmr;
    logic        write_permit_latch;
    logic        vperm;
    logic        deep;
    logic        enh;
    logic [15:0] stat;
    logic [15:0] shown;
    sfc_snap_t   snap;
    logic        cmd_valid;
    sfc_cmd_t    cmd;
  } sfc_core_t;

  sfc_link_t lr, ln;
  sfc_desc_t dr, dn;
  sfc_tx_t   tr, tn;
  sfc_core_t cr, cn;

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  // Shifts one or two line bits in, MSB first
  function automatic logic [23:0] shift_in(input logic [23:0] v, input logic two,
                                           input logic [1:0] b);
    return two ? {v[21:0], b} : {v[22:0], b[0]};
  endfunction

  // Framing of each known opcode; unknown, or asleep except for OPC_WAKE_ID, gives known = 0
  function automatic sfc_info_t cmd_info(input logic [7:0] op, input logic deep);
    sfc_info_t f;
    f = '0;
    f.known = 1'b1;
    unique case (op)
      OPC_READ, OPC_LEGACY_ID, OPC_WAKE_ID: begin
        f.has_addr = 1'b1;
        f.dir      = DIR_OUT;
      end
      OPC_FAST_READ, OPC_SEC_RD: begin
        f.has_addr  = 1'b1;
        f.has_dummy = 1'b1;
        f.dir       = DIR_OUT;
      end
      OPC_DUAL_OUT_READ, OPC_DUAL_LEGACY_ID: begin
        f.has_addr  = 1'b1;
        f.has_dummy = 1'b1;
        f.dir       = DIR_OUT;
        f.dual_data = 1'b1;
      end
      OPC_DUAL_IO_READ: begin
        f.has_addr  = 1'b1;
        f.has_dummy = 1'b1;
        f.dir       = DIR_OUT;
        f.dual_addr = 1'b1;
        f.dual_data = 1'b1;
      end
      OPC_PAGE_CLR, OPC_4K_CLR, OPC_HALF_BLK_CLR, OPC_FULL_BLK_CLR, OPC_SEC_CLR: begin
        f.has_addr = 1'b1;
      end
      OPC_ALL_CLR_A, OPC_ALL_CLR_B, OPC_PERMIT_SET, OPC_PERMIT_CLR, OPC_VOL_PERMIT,
      OPC_SLEEP, OPC_ENH_EXIT: begin
        f.dir = DIR_IN;  // Extra bits are counted so the core can reject them; OPC_ENH_EXIT acts whatever follows
      end
      OPC_PAGE_WR, OPC_SEC_WR: begin
        f.has_addr = 1'b1;
        f.dir      = DIR_IN;
      end
      OPC_DUAL_PAGE_WR: begin
        f.has_addr  = 1'b1;
        f.dir       = DIR_IN;
        f.dual_data = 1'b1;
      end
      OPC_STAT_WR: f.dir = DIR_IN;
      OPC_STAT_LO_RD, OPC_STAT_HI_RD, OPC_PART_CODE: f.dir = DIR_OUT;
      OPC_BUSY_MON: begin
        f.has_dummy = 1'b1;
        f.dir       = DIR_MON;
      end
      default: f.known = 1'b0;
    endcase
    if (deep && op != OPC_WAKE_ID) begin
      f.known = 1'b0;
    end
    return f;
  endfunction

  // Byte returned at position idx of an output phase
  function automatic logic [7:0] next_byte(input logic [7:0] op, input logic [1:0] idx,
                                           input logic a0, input logic [15:0] st);
    case (op)
      OPC_STAT_LO_RD: return st[7:0];
      OPC_STAT_HI_RD: return st[15:8];
      OPC_PART_CODE: begin
        if (idx == 2'h0) begin
          return MAKER_ID;
        end else if (idx == 2'h1) begin
          return PART_HI;
        end
        return PART_LO;
      end
      OPC_LEGACY_ID, OPC_DUAL_LEGACY_ID: return (idx[0] ^ a0) ? PART_LO : MAKER_ID;
      OPC_WAKE_ID: return ELEC_ID;
      default: return ARRAY_FILL;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Link domain: receive and output shifting
  // ------------------------------------------------------------------
  logic [1:0]  pins;
  logic [5:0]  istep;
  logic [3:0]  ostep;
  logic [23:0] tmp;
  logic        enter_body;

  assign pins = {i_io1_in, i_io0_in};

  // Next link state from one serial clock rising edge
  always_comb begin
    ln         = lr;
    dn         = dr;
    tmp        = '0;
    enter_body = 1'b0;
    ostep      = lr.info.dual_data ? 4'h2 : 4'h1;
    istep      = lr.info.dual_addr ? 6'h02 : 6'h01;
    ln.wip_s1  = cr.busy;
    ln.wip_s2  = lr.wip_s1;
    // Output byte stream, refilled for as long as the host clocks
    if (lr.phase == PH_DOUT) begin
      if (lr.ocnt == ostep) begin
        ln.idx  = (dr.opcode == OPC_PART_CODE && lr.idx == 2'h2) ? 2'h0 : lr.idx + 2'h1;
        ln.osr  = next_byte(dr.opcode, ln.idx, dr.addr[0], cr.snap.status);
        ln.ocnt = OUT_BITS;
      end else begin
        ln.osr  = lr.info.dual_data ? {lr.osr[5:0], 2'h0} : {lr.osr[6:0], 1'b0};
        ln.ocnt = lr.ocnt - ostep;
      end
    end
    if (lr.phase == PH_BUSY) begin
      ln.osr = {8{lr.wip_s2}};
    end
    unique case (lr.phase)
      PH_OPC: begin
        if (lr.cnt == 6'h00) begin
          dn.enh_start = 1'b0;
          dn.hdr_done  = 1'b0;
          dn.nbits     = '0;
        end
        if (lr.cnt == 6'h00 && cr.snap.enh) begin
          // Enhanced continuous read: frame starts straight at the address
          dn.enh_start = 1'b1;
          dn.opcode    = OPC_DUAL_IO_READ;
          ln.info      = cmd_info(OPC_DUAL_IO_READ, 1'b0);
          dn.addr      = shift_in(dr.addr, 1'b1, pins);
          ln.cnt       = 6'h02;
          ln.phase     = PH_ADDR;
        end else begin
          ln.sr  = {lr.sr[6:0], i_io0_in};
          ln.cnt = lr.cnt + 6'h01;
          if (ln.cnt == OPC_BITS) begin
            dn.opcode = ln.sr;
            ln.info   = cmd_info(ln.sr, cr.snap.deep);
            ln.cnt    = '0;
            if (!ln.info.known) begin
              ln.phase = PH_IGNORE;
            end else if (ln.info.has_addr) begin
              ln.phase = PH_ADDR;
            end else if (ln.info.has_dummy) begin
              ln.phase = PH_DUMMY;
            end else begin
              enter_body = 1'b1;
            end
          end
        end
      end
      PH_ADDR: begin
        dn.addr = shift_in(dr.addr, lr.info.dual_addr, pins);
        ln.cnt  = lr.cnt + istep;
        if (ln.cnt == ADDR_BITS) begin
          ln.cnt = '0;
          if (lr.info.has_dummy) begin
            ln.phase = PH_DUMMY;
          end else begin
            enter_body = 1'b1;
          end
        end
      end
      PH_DUMMY: begin
        tmp     = shift_in({16'h0000, dr.mode}, lr.info.dual_addr, pins);
        dn.mode = tmp[7:0];
        ln.cnt  = lr.cnt + istep;
        if (ln.cnt == DUMMY_BITS) begin
          enter_body = 1'b1;
        end
      end
      PH_DIN: begin
        tmp      = shift_in({8'h00, dr.wdata}, lr.info.dual_data, pins);
        dn.wdata = tmp[15:0];
        if (dr.nbits > NBITS_MAX - 5'h02) begin
          dn.nbits = NBITS_MAX;
        end else begin
          dn.nbits = dr.nbits + (lr.info.dual_data ? 5'h02 : 5'h01);
        end
      end
      PH_DOUT, PH_BUSY, PH_IGNORE: begin
      end
    endcase
    // Header complete: choose the body of the command
    if (enter_body) begin
      dn.hdr_done = 1'b1;
      ln.cnt      = '0;
      unique case (ln.info.dir)
        DIR_OUT: begin
          ln.phase = PH_DOUT;
          ln.idx   = 2'h0;
          ln.osr   = next_byte(dn.opcode, 2'h0, dn.addr[0], cr.snap.status);
          ln.ocnt  = OUT_BITS;
        end
        DIR_MON: begin
          ln.phase = PH_BUSY;
          ln.osr   = {8{lr.wip_s2}};  // First monitor bit is already valid
        end
        DIR_IN, DIR_NONE:  ln.phase = PH_DIN;
      endcase
    end
  end

  // Frame state, cleared whenever select is high
  always_ff @(posedge i_spi_sclk or posedge i_spi_csn) begin
    if (i_spi_csn) begin
      lr <= '0;
    end else begin
      lr <= ln;
    end
  end

  // Command descriptor, held after the frame for the core domain
  always_ff @(posedge i_spi_sclk) begin
    if (!i_spi_csn) begin
      dr <= dn;
    end
  end

  // Output drivers change on the falling edge
  always_comb begin
    tn.io1_oe  = (lr.phase == PH_DOUT) || (lr.phase == PH_BUSY);
    tn.io0_oe  = (lr.phase == PH_DOUT) && lr.info.dual_data;
    tn.io1_out = lr.osr[7];
    tn.io0_out = lr.osr[6];
  end

  always_ff @(negedge i_spi_sclk or posedge i_spi_csn) begin
    if (i_spi_csn) begin
      tr <= '0;
    end else begin
      tr <= tn;
    end
  end

  assign o_io0_out = tr.io0_out;
  assign o_io0_oe  = tr.io0_oe;
  assign o_io1_out = tr.io1_out;
  assign o_io1_oe  = tr.io1_oe;

  // ------------------------------------------------------------------
  // Core domain: command effects at the end of each frame
  // ------------------------------------------------------------------
  logic        frame_end;
  logic        bare;
  logic        start_op;
  logic [15:0] wr_val;
  logic [15:0] new_stat;

  // Next core state
  always_comb begin
    cn           = cr;
    cn.sel_s1    = ~i_spi_csn;
    cn.sel_s2    = cr.sel_s1;
    cn.sel_s3    = cr.sel_s2;
    cn.cmd_valid = 1'b0;
    frame_end    = cr.sel_s3 && !cr.sel_s2;
    bare         = dr.hdr_done && (dr.nbits == 5'h00);
    start_op     = 1'b0;
    wr_val       = (dr.nbits == TWO_BYTES) ? {dr.wdata[7:0], dr.wdata[15:8]}
                                            : {8'h00, dr.wdata[7:0]};
    new_stat     = (cr.stat & ~STAT_WR_MASK) | (wr_val & STAT_WR_MASK);
    if (dr.nbits == ONE_BYTE) begin
      new_stat[15:8] = cr.stat[15:8];
    end
    // Self-timed operation; completion clears the latch before any new set
    if (cr.busy) begin
      if (cr.tmr == 12'h001) begin
        cn.busy = 1'b0;
        cn.write_permit_latch  = 1'b0;
      end else begin
        cn.tmr = cr.tmr - 12'h001;
      end
    end
    if (frame_end) begin
      cn.vperm = 1'b0;
      case (dr.opcode)
        OPC_PERMIT_SET: begin
          if (bare) begin
            cn.write_permit_latch = 1'b1;
          end
        end
        OPC_PERMIT_CLR: begin
          if (bare) begin
            cn.write_permit_latch = 1'b0;
          end
        end
        OPC_VOL_PERMIT: cn.vperm = bare;
        OPC_STAT_WR: begin
          if (dr.hdr_done && (dr.nbits == ONE_BYTE || dr.nbits == TWO_BYTES) && !cn.busy) begin
            if (cr.vperm) begin
              cn.stat = new_stat;
            end else if (cr.write_permit_latch) begin
              cn.stat  = new_stat;
              start_op = 1'b1;
            end
          end
        end
        OPC_PAGE_CLR, OPC_4K_CLR, OPC_HALF_BLK_CLR, OPC_FULL_BLK_CLR, OPC_SEC_CLR,
        OPC_ALL_CLR_A, OPC_ALL_CLR_B: begin
          start_op = bare && cn.write_permit_latch && !cn.busy;
        end
        OPC_PAGE_WR, OPC_DUAL_PAGE_WR, OPC_SEC_WR: begin
          start_op = dr.hdr_done && dr.nbits >= ONE_BYTE && cn.write_permit_latch && !cn.busy;
        end
        OPC_SLEEP: begin
          if (bare && !cn.busy) begin
            cn.deep = 1'b1;
          end
        end
        OPC_WAKE_ID: begin
          if (dr.hdr_done) begin
            cn.deep = 1'b0;
          end
        end
        OPC_ENH_EXIT: cn.enh = 1'b0;
        OPC_DUAL_IO_READ: begin
          if (dr.enh_start && dr.addr[23:16] == OPC_ENH_EXIT) begin
            cn.enh = 1'b0;
          end else if (dr.hdr_done) begin
            cn.enh = (dr.mode[7:4] == ENH_KEY);
          end else begin
            cn.enh = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Accepted modifying command: report it and run the busy time
    if (start_op) begin
      cn.busy      = 1'b1;
      cn.tmr       = OP_BUSY_CYC;
      cn.cmd_valid = 1'b1;
      cn.cmd       = '{opcode: dr.opcode, addr: dr.addr};
    end
    cn.shown = {cn.stat[15:2], cn.write_permit_latch, cn.busy};
    // Snapshot for the link, frozen while a frame is under way
    if (!cr.sel_s2) begin
      cn.snap = '{status: cr.shown, deep: cr.deep, enh: cr.enh};
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      cr <= '0;
    end else begin
      cr <= cn;
    end
  end

  // Core outputs straight from state flops
  assign o_busy               = cr.busy;
  assign o_write_permit_latch = cr.write_permit_latch;
  assign o_deep_sleep         = cr.deep;
  assign o_status             = cr.shown;
  assign o_cmd_valid          = cr.cmd_valid;
  assign o_cmd                = cr.cmd;

endmodule

// [shared/sfc_pkg.sv]
// Package for the serial flash command interpreter: opcodes, identity
// bytes, status layout, bit counts, timing counts and shared types.
// Assumes a 125 MHz core clock and a serial link framed by chip select.
package sfc_pkg;

  // ------------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OPC_READ           = 8'h03;
  localparam logic [7:0] OPC_FAST_READ      = 8'h0B;
  localparam logic [7:0] OPC_DUAL_OUT_READ  = 8'h3B;
  localparam logic [7:0] OPC_DUAL_IO_READ   = 8'hBB;
  localparam logic [7:0] OPC_PAGE_CLR       = 8'h81;
  localparam logic [7:0] OPC_4K_CLR         = 8'h20;
  localparam logic [7:0] OPC_HALF_BLK_CLR   = 8'h52;
  localparam logic [7:0] OPC_FULL_BLK_CLR   = 8'hD8;
  localparam logic [7:0] OPC_ALL_CLR_A      = 8'h60;
  localparam logic [7:0] OPC_ALL_CLR_B      = 8'hC7;
  localparam logic [7:0] OPC_PAGE_WR        = 8'h02;
  localparam logic [7:0] OPC_DUAL_PAGE_WR   = 8'hA2;
  localparam logic [7:0] OPC_PERMIT_SET     = 8'h06;
  localparam logic [7:0] OPC_PERMIT_CLR     = 8'h04;
  localparam logic [7:0] OPC_VOL_PERMIT     = 8'h50;
  localparam logic [7:0] OPC_SEC_CLR        = 8'h44;
  localparam logic [7:0] OPC_SEC_WR         = 8'h42;
  localparam logic [7:0] OPC_SEC_RD         = 8'h48;
  localparam logic [7:0] OPC_STAT_LO_RD     = 8'h05;
  localparam logic [7:0] OPC_STAT_HI_RD     = 8'h35;
  localparam logic [7:0] OPC_BUSY_MON       = 8'h25;
  localparam logic [7:0] OPC_STAT_WR        = 8'h01;
  localparam logic [7:0] OPC_PART_CODE      = 8'h9F;
  localparam logic [7:0] OPC_LEGACY_ID      = 8'h90;
  localparam logic [7:0] OPC_DUAL_LEGACY_ID = 8'h92;
  localparam logic [7:0] OPC_SLEEP          = 8'hB9;
  localparam logic [7:0] OPC_WAKE_ID        = 8'hAB;
  localparam logic [7:0] OPC_ENH_EXIT       = 8'hFF;

  // ------------------------------------------------------------------
  // Returned bytes and enhanced read mode key (identity values are arbitrary)
  // ------------------------------------------------------------------
  localparam logic [7:0] ARRAY_FILL = 8'hFF;  // Erased array content
  localparam logic [7:0] MAKER_ID   = 8'h5A;  // Arbitrary
  localparam logic [7:0] PART_HI    = 8'h3C;  // Arbitrary
  localparam logic [7:0] PART_LO    = 8'h13;  // Arbitrary
  localparam logic [7:0] ELEC_ID    = 8'h12;  // Arbitrary
  localparam logic [3:0] ENH_KEY    = 4'hA;   // Mode nibble keeping enhanced read

  // ------------------------------------------------------------------
  // Status layout and bit counts
  // ------------------------------------------------------------------
  localparam logic [15:0] STAT_WR_MASK = 16'h7BFC;  // S15, S10, S1, S0 fixed
  localparam logic [5:0]  OPC_BITS     = 6'h08;
  localparam logic [5:0]  ADDR_BITS    = 6'h18;
  localparam logic [5:0]  DUMMY_BITS   = 6'h08;
  localparam logic [3:0]  OUT_BITS     = 4'h8;
  localparam logic [4:0]  NBITS_MAX    = 5'h1F;
  localparam logic [4:0]  ONE_BYTE     = 5'h08;
  localparam logic [4:0]  TWO_BYTES    = 5'h10;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int          CORE_CLK_NS = 8;
  localparam int          OP_BUSY_NS  = 8000;
  localparam logic [11:0] OP_BUSY_CYC = 12'((OP_BUSY_NS + CORE_CLK_NS - 1) / CORE_CLK_NS);

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_OPC    = 3'h0,
    PH_ADDR   = 3'h1,
    PH_DUMMY  = 3'h3,
    PH_DIN    = 3'h2,
    PH_DOUT   = 3'h6,
    PH_BUSY   = 3'h7,
    PH_IGNORE = 3'h5
  } sfc_phase_t;

  typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_IN = 2'h1, DIR_OUT = 2'h2, DIR_MON = 2'h3}
    sfc_dir_t;

  typedef struct packed {
    logic     known;
    logic     has_addr;
    logic     has_dummy;
    sfc_dir_t dir;
    logic     dual_addr;
    logic     dual_data;
  } sfc_info_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
  } sfc_cmd_t;

  typedef struct packed {
    logic [15:0] status;
    logic        deep;
    logic        enh;
  } sfc_snap_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  mode;
    logic        hdr_done;
    logic [4:0]  nbits;
    logic [15:0] wdata;
    logic        enh_start;
  } sfc_desc_t;

endpackage

// [test/sfc_chk_asserts.sv]
// Checker on the core-side outputs and line enables of the flash command block.
// Bound to the block from the bench top file.
`timescale 1ns/10ps

module sfc_chk
  import sfc_pkg::*;
(
  input wire logic              i_core_clk,
  input wire logic              i_rstn,
  input wire logic              i_spi_csn,
  input wire logic              o_io0_oe,
  input wire logic              o_io1_oe,
  input wire logic              o_busy,
  input wire logic              o_write_permit_latch,
  input wire logic              o_cmd_valid,
  input wire sfc_pkg::sfc_cmd_t o_cmd
);
  logic [11:0] bcnt_r;

  // Counts the cycles that an operation stays in flight
  always_ff @(posedge i_core_clk) begin
    bcnt_r <= (o_busy && i_rstn) ? bcnt_r + 12'h001 : 12'h000;
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  AST_BUSY_LEN: assert property ($fell(o_busy) |-> bcnt_r == OP_BUSY_CYC)
    else $error("busy span wrong");
  AST_BUSY_CAP: assert property (bcnt_r <= OP_BUSY_CYC)
    else $error("busy too long");
  AST_LATCH_DONE: assert property ($fell(o_busy) |-> !o_write_permit_latch)
    else $error("latch kept after op");
  AST_CMD_BUSY: assert property (o_cmd_valid && o_cmd.opcode != OPC_STAT_WR |=> o_busy)
    else $error("accepted op not busy");
  AST_BUSY_CAUSE: assert property ($rose(o_busy) |-> o_cmd_valid)
    else $error("busy without accept");
  AST_CMD_OPC: assert property (o_cmd_valid |-> o_cmd.opcode inside {8'h81, 8'h20, 8'h52,
    8'hD8, 8'h60, 8'hC7, 8'h02, 8'hA2, 8'h44, 8'h42, 8'h01})
    else $error("bad accepted opcode");
  AST_PULSE: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("accept pulse too long");
  AST_HOLD: assert property (!o_cmd_valid |-> $stable(o_cmd))
    else $error("command changed");
  AST_OE_IDLE: assert property (i_spi_csn && $past(i_spi_csn) |-> !o_io0_oe && !o_io1_oe)
    else $error("driving while deselected");
  AST_OE_PAIR: assert property (o_io0_oe |-> o_io1_oe)
    else $error("line 0 driven alone");
endmodule

// [test/sfc_host_model.sv]
// Host controller model: drives select, serial clock and data lines.
// Assumes the bench resolves the wire levels from the design enables.
`timescale 1ns/10ps

module sfc_host_model (
  input  wire logic i_io0,
  input  wire logic i_io1,
  input  wire logic i_oe,
  output logic      o_csn,
  output logic      o_sclk,
  output logic      o_io0,
  output logic      o_io1
);
  logic seen_oe;

  // Deselected with clock parked low while supply settles
  initial begin
    o_sclk = 1'b0;
    o_io0 = 1'b0;
    o_io1 = 1'b1;
    seen_oe = 1'b0;
    #1 o_csn = 1'b1; // Real rising edge clears the link state before first use
  end

  // One frame: header bits MSB first, then answer bits
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                       input bit dual, output logic [31:0] rx);
    rx = '0;
    seen_oe = 1'b0;
    o_csn = 1'b0;
    for (int i = ntx - 1; i >= 0; i--) begin
      #24 o_sclk = 1'b0;
      o_io0 = tx[i];
      o_io1 = ~o_io1; // Released line toggles
      #24 o_sclk = 1'b1;
    end
    for (int i = 0; i < nrx; i++) begin
      #24 o_sclk = 1'b0;
      o_io0 = ~o_io0; // Released lines toggle
      o_io1 = ~o_io1;
      #24 o_sclk = 1'b1;
      seen_oe = seen_oe | i_oe;
      rx = dual ? {rx[29:0], i_io1, i_io0} : {rx[30:0], i_io1};
    end
    #24 o_sclk = 1'b0;
    #24 o_csn = 1'b1; // Deselect ends the command
    #96;
  endtask
endmodule

// [test/sfc_flash_cmd_tb.sv]
// Bench for the flash command block with a host model on the link.
// Assumes the checker file is compiled before this one.
`timescale 1ns/10ps

module sfc_flash_cmd_tb;
  import sfc_pkg::*;
  logic clk, rstn, csn, sclk, h0, h1, w0, w1, o0, oe0, o1, oe1, busy, wpl, deep, cval;
  logic [15:0] stat;
  sfc_cmd_t    cmd;
  logic [31:0] rx;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          nval = 0;
  int          n0;

  // Wire levels follow whoever drives
  assign w0 = oe0 ? o0 : h0;
  assign w1 = oe1 ? o1 : h1;

  sfc_flash_cmd uut (.i_core_clk(clk), .i_rstn(rstn), .i_spi_sclk(sclk), .i_spi_csn(csn),
    .i_io0_in(w0), .i_io1_in(w1), .o_io0_out(o0), .o_io0_oe(oe0), .o_io1_out(o1),
    .o_io1_oe(oe1), .o_busy(busy), .o_write_permit_latch(wpl), .o_deep_sleep(deep),
    .o_status(stat), .o_cmd_valid(cval), .o_cmd(cmd));
  sfc_host_model h (.i_io0(w0), .i_io1(w1), .i_oe(oe1), .o_csn(csn), .o_sclk(sclk),
    .o_io0(h0), .o_io1(h1));

  // Counts accepted commands
  always @(posedge clk) begin
    if (cval === 1'b1) nval++;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic go(input logic [63:0] tx, input int n, input int nr, input bit d);
    h.frame(tx, n, nr, d, rx);
  endtask

  task automatic idle();
    for (int i = 0; i < 1100 && busy !== 1'b0; i++) @(negedge clk);
    chk("idle", 0, busy);
  endtask

  task automatic t_latch();
    go(8'h06, 8, 0, 0);
    chk("latch", 1, wpl);
    go(8'h05, 8, 8, 0);
    chk("stat_lo", 8'h02, rx);
    go(8'h35, 8, 8, 0);
    chk("stat_hi", 8'h00, rx);
    go(8'h04, 8, 0, 0);
    chk("latch", 0, wpl);
  endtask

  task automatic t_ids();
    go(8'h9F, 8, 24, 0);
    chk("part", {MAKER_ID, PART_HI, PART_LO}, rx);
    go({8'h90, 24'h0}, 32, 16, 0);
    chk("legacy", {MAKER_ID, PART_LO}, rx);
    go({8'h0B, 24'h10, 8'h0}, 40, 16, 0);
    chk("fast", {2{ARRAY_FILL}}, rx);
    go({8'h3B, 24'h10, 8'h0}, 40, 4, 1);
    chk("dual", ARRAY_FILL, rx);
  endtask

  task automatic t_erase();
    n0 = nval;
    go({8'h20, 24'h012345}, 32, 0, 0);
    chk("refused", n0, nval);
    go(8'h06, 8, 0, 0);
    go({8'h20, 24'h012345}, 32, 0, 0);
    chk("accept", n0 + 1, nval);
    chk("cmd", {8'h20, 24'h012345}, cmd);
    go(8'h05, 8, 8, 0);
    chk("stat_busy", 8'h03, rx);
    go({8'h25, 8'h00}, 16, 4, 0);
    chk("mon_busy", 4'hF, rx);
    idle();
    chk("latch", 0, wpl);
    go({8'h25, 8'h00}, 16, 4, 0);
    chk("mon_idle", 4'h0, rx);
    go(8'h06, 8, 0, 0);
    go({8'h02, 24'h000100, 8'hA5}, 40, 0, 0);
    chk("pgwr", n0 + 2, nval);
    chk("pgwr_cmd", {8'h02, 24'h000100}, cmd);
    idle();
  endtask

  task automatic t_status_write();
    n0 = nval;
    go(8'h06, 8, 0, 0);
    go({8'h01, 4'h5}, 12, 0, 0);
    chk("status_write_bad", n0, nval);
    go({8'h01, 8'h0C}, 16, 0, 0);
    chk("status_write", n0 + 1, nval);
    idle();
    go(8'h05, 8, 8, 0);
    chk("status_write_val", 8'h0C, rx);
    chk("stat_pin", 16'h000C, stat);
    go(8'h50, 8, 0, 0);
    go({8'h01, 8'h30}, 16, 0, 0);
    chk("vol_stat", 16'h0030, stat);
    chk("vol_quiet", n0 + 1, nval);
    chk("vol_idle", 0, busy);
  endtask

  task automatic t_sleep();
    go(8'hB9, 8, 0, 0);
    chk("deep", 1, deep);
    go(8'h05, 8, 8, 0);
    chk("deep_quiet", 0, h.seen_oe);
    go({8'hAB, 24'h0}, 32, 8, 0);
    chk("elec", ELEC_ID, rx);
    chk("wake", 0, deep);
    go(8'h77, 8, 8, 0);
    chk("unknown", 0, h.seen_oe);
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    #70000; // Supply settle wait before first select
    t_latch();
    t_ids();
    t_erase();
    t_status_write();
    t_sleep();
    give_verdict();
  end

  // Watchdog well beyond the expected run
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
endmodule

bind sfc_flash_cmd sfc_chk u_chk (.i_core_clk, .i_rstn, .i_spi_csn, .o_io0_oe, .o_io1_oe,
  .o_busy, .o_write_permit_latch, .o_cmd_valid, .o_cmd);
